// [hw/mtc_pkg.sv]
// Shared constants, types and helpers of the memory table copy link
package mtc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_GAP_NS = 2000;
  localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Tables and control word fields
  // ----------------------------------------
  localparam int N_ENTRY = 128;
  localparam int ENTRY_W = 16;
  localparam int HOST_MEM_N = 8;
  localparam int TYPE_LSB = 12;
  localparam logic [3:0] COPY_STRING = 4'h0;
  localparam logic [3:0] COPY_NUMERAL = 4'h1;
  localparam logic [3:0] COPY_INVALID = 4'hf;
  localparam logic [9:0] ENTRY_MAX = 10'h07f;
  localparam logic [15:0] LINK_RELAY_LAST = 16'h00c7;
  localparam logic [15:0] LINK_TO_GIO = 16'h03e8;
  // ----------------------------------------
  // Host register map and reset values
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_LOC = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WORDS = 8'h0c;
  localparam logic [2:0] REG_MEM_HI = 3'h1;
  localparam logic [3:0] RST_LOC_AREA = 4'ha;
  localparam logic [15:0] RST_LOC_ADDR = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [3:0] {
    AREA_GENERAL_IO = 4'h0, AREA_HOLD = 4'h1, AREA_AUX = 4'h2,
    AREA_LINK_RELAY = 4'h3, AREA_TIMER_PRESENT_VALUE = 4'h4,
    AREA_TIMER_DONE = 4'h5, AREA_COUNTER_PRESENT_VALUE = 4'h6,
    AREA_COUNTER_DONE = 4'h7, AREA_WORK = 4'h8, AREA_TASK_FLAG = 4'h9,
    AREA_DATA = 4'ha, AREA_EXT = 4'hb
  } mtc_area_t;
  typedef enum logic [2:0] {
    DEV_SWEEP = 3'h0, DEV_CTRL0 = 3'h1, DEV_CTRL1 = 3'h2,
    DEV_EVAL = 3'h3, DEV_DISP = 3'h4
  } mtc_dev_st_t;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'h0, HOST_KILL = 3'h1, HOST_DEST = 3'h2,
    HOST_SRC = 3'h3, HOST_HOLD = 3'h4
  } mtc_host_st_t;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Relay words 0..199 move to general words 1000..1199
  function automatic logic [19:0] mtc_xlate(input logic [3:0] area, input logic [15:0] addr);
    if (area == AREA_LINK_RELAY && addr <= LINK_RELAY_LAST)
      return {AREA_GENERAL_IO, 16'(addr + LINK_TO_GIO)};
    return {area, addr};
  endfunction
  // Areas able to hold the control area
  function automatic logic mtc_area_ok(input logic [3:0] area);
    return !(area inside {AREA_TIMER_PRESENT_VALUE, AREA_TIMER_DONE,
      AREA_COUNTER_PRESENT_VALUE, AREA_COUNTER_DONE, AREA_TASK_FLAG}) && area <= AREA_EXT;
  endfunction
  // Three BCD digits to entry index, top bit flags a legal index
  function automatic logic [7:0] mtc_bcd_idx(input logic [11:0] b);
    logic [9:0] v;
    logic ok;
    v = 10'(b[11:8]) * 10'h064 + 10'(b[7:4]) * 10'h00a + 10'(b[3:0]);
    ok = b[11:8] <= 4'h9 && b[7:4] <= 4'h9 && b[3:0] <= 4'h9 && v <= ENTRY_MAX;
    return {ok, v[6:0]};
  endfunction
endpackage

// [hw/mtc_link_if.sv]
// Word read link between terminal unit and host controller
`timescale 1ns/1ns
`default_nettype none
interface mtc_link_if (
  input wire logic clk
);
  logic req;
  logic [3:0] area;
  logic [15:0] addr;
  logic ack;
  logic [15:0] data;
  modport dev (input clk, output req, output area, output addr, input ack, input data);
  modport host (input clk, input req, input area, input addr, output ack, output data);
endinterface
`default_nettype wire

// [hw/mtc_dev.sv]
// Terminal unit end: polls the copy setting words and copies table entries
//
// Function
// - Type 0 strings, type 1 numerals
// - Entry numbers 000 to 127 index table
// - Valid command copies source into destination entry
// - Other copy types never copy
// - Copy only when sampled area changed
// - Host repeats via invalid type first
// - Host writes destination before source
// - Area may be sampled mid update
// - Read only displayed entries after initialization
// - Numeral copy moves raw word only
// - Relay words 0-199 map to 1000-1199
// - Host keeps area out of forbidden areas
`timescale 1ns/1ns
`default_nettype none
module mtc_dev
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to host
  mtc_link_if.dev lk,
  // Control area location
  input wire logic [3:0] ctrl_area,
  input wire logic [15:0] ctrl_addr,
  // Table allocation in host memory
  input wire logic alloc_en,
  input wire logic [3:0] alloc_area,
  input wire logic [15:0] alloc_base,
  // Displayed entry
  input wire logic disp_num,
  input wire logic [6:0] disp_idx,
  output logic [15:0] disp_data,
  // Table lookup
  input wire logic look_num,
  input wire logic [6:0] look_idx,
  output logic [15:0] look_data,
  // Status
  output logic copy_done,
  output logic init_done
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mtc_dev_st_t st;
    logic req;
    logic [3:0] area;
    logic [15:0] addr;
    logic [7:0] idx;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] ref0;
    logic [15:0] ref1;
    logic ref_ok;
    logic [N_ENTRY-1:0][ENTRY_W-1:0] str_tbl;
    logic [N_ENTRY-1:0][ENTRY_W-1:0] num_tbl;
    logic [15:0] disp_data;
    logic [15:0] look_data;
    logic copy_done;
    logic init_done;
  } mtc_dev_state_t;

  mtc_dev_state_t cur;
  mtc_dev_state_t next_cur;
  logic [3:0] ctype;
  logic [7:0] dst;
  logic [7:0] src;
  logic changed;

  // ----------------------------------------
  // Decode of the sampled words
  // ----------------------------------------
  assign ctype = cur.w0[TYPE_LSB+3:TYPE_LSB];
  assign dst = mtc_bcd_idx(cur.w0[11:0]);
  assign src = mtc_bcd_idx(cur.w1[11:0]);
  assign changed = cur.w0 != cur.ref0 || cur.w1 != cur.ref1;

  // Link, display, lookup and status outputs
  assign lk.req = cur.req;
  assign lk.area = cur.area;
  assign lk.addr = cur.addr;
  assign disp_data = cur.disp_data;
  assign look_data = cur.look_data;
  assign copy_done = cur.copy_done;
  assign init_done = cur.init_done;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.copy_done = 1'b0;
    case (cur.st)
      // Load every allocated entry once
      DEV_SWEEP:
      begin
        if (!alloc_en && !cur.req) // Never abandon a read in flight
        begin
          next_cur.st = DEV_CTRL0;
          next_cur.init_done = 1'b1;
        end
        else if (!cur.req)
        begin
          next_cur.req = 1'b1;
          {next_cur.area, next_cur.addr} = mtc_xlate(alloc_area, 16'(alloc_base + {8'h00, cur.idx}));
        end
        else if (lk.ack)
        begin
          next_cur.req = 1'b0;
          if (cur.idx[7])
            next_cur.num_tbl[cur.idx[6:0]] = lk.data;
          else
            next_cur.str_tbl[cur.idx[6:0]] = lk.data;
          next_cur.idx = 8'(cur.idx + 8'h01);
          if (cur.idx == 8'hff)
          begin
            next_cur.st = DEV_CTRL0;
            next_cur.init_done = 1'b1;
          end
        end
      end
      // Sample type and destination word; host may be mid update
      DEV_CTRL0:
      begin
        if (!cur.req)
        begin
          next_cur.req = 1'b1;
          {next_cur.area, next_cur.addr} = mtc_xlate(ctrl_area, ctrl_addr);
        end
        else if (lk.ack)
        begin
          next_cur.req = 1'b0;
          next_cur.w0 = lk.data;
          next_cur.st = DEV_CTRL1;
        end
      end
      // Sample source word
      DEV_CTRL1:
      begin
        if (!cur.req)
        begin
          next_cur.req = 1'b1;
          {next_cur.area, next_cur.addr} = mtc_xlate(ctrl_area, 16'(ctrl_addr + 16'h0001));
        end
        else if (lk.ack)
        begin
          next_cur.req = 1'b0;
          next_cur.w1 = lk.data;
          next_cur.st = DEV_EVAL;
        end
      end
      // Compare with reference and copy
      DEV_EVAL:
      begin
        next_cur.st = DEV_DISP;
        if (!cur.ref_ok)
        begin
          next_cur.ref_ok = 1'b1;
          next_cur.ref0 = cur.w0;
          next_cur.ref1 = cur.w1;
        end
        else if (changed)
        begin
          next_cur.ref0 = cur.w0;
          next_cur.ref1 = cur.w1;
          if (dst[7] && src[7])
          begin
            // Raw word copy, format mismatch is the user's concern
            if (ctype == COPY_STRING)
            begin
              next_cur.str_tbl[dst[6:0]] = cur.str_tbl[src[6:0]];
              next_cur.copy_done = 1'b1;
            end
            else if (ctype == COPY_NUMERAL)
            begin
              next_cur.num_tbl[dst[6:0]] = cur.num_tbl[src[6:0]];
              next_cur.copy_done = 1'b1;
            end
          end
        end
      end
      // Refresh the displayed entry only
      DEV_DISP:
      begin
        if (!alloc_en && !cur.req) // A stray answer would land in the control words
          next_cur.st = DEV_CTRL0;
        else if (!cur.req)
        begin
          next_cur.req = 1'b1;
          next_cur.idx = {disp_num, disp_idx};
          {next_cur.area, next_cur.addr} = mtc_xlate(alloc_area, 16'(alloc_base + {8'h00, disp_num, disp_idx}));
        end
        else if (lk.ack)
        begin
          next_cur.req = 1'b0;
          if (cur.idx[7])
            next_cur.num_tbl[cur.idx[6:0]] = lk.data;
          else
            next_cur.str_tbl[cur.idx[6:0]] = lk.data;
          next_cur.st = DEV_CTRL0;
        end
      end
      default:
      begin
        next_cur.st = DEV_SWEEP;
      end
    endcase
    // Display changes with the tables in the same cycle; lookup follows them one cycle later
    next_cur.disp_data = disp_num ? next_cur.num_tbl[disp_idx] : next_cur.str_tbl[disp_idx];
    next_cur.look_data = look_num ? cur.num_tbl[look_idx] : cur.str_tbl[look_idx];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cur <= '0;
    else
      cur <= next_cur;
  end
endmodule
`default_nettype wire

// [hw/mtc_host.sv]
// Host controller end: AXI4-Lite orders, copy setting words, link answers
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mtc_host
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to terminal unit
  mtc_link_if.host lk,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mtc_host_st_t st;
    logic [7:0] gap;
    logic awp;
    logic [ADDR_W-1:0] awaddr;
    logic wp;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [19:0] loc;
    logic loc_err;
    logic cmd_ref;
    logic [31:0] cmd;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [HOST_MEM_N-1:0][15:0] mem;
    logic ack;
    logic [15:0] ldata;
  } mtc_host_state_t;

  mtc_host_state_t cur;
  mtc_host_state_t next_cur;
  logic [31:0] wval;
  logic [19:0] cloc;
  logic [31:0] status;

  // Byte lane merge over the old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  assign cloc = mtc_xlate(cur.loc[19:16], cur.loc[15:0]);
  assign status = {29'h0, cur.loc_err, cur.cmd_ref, cur.st != HOST_IDLE};
  assign s_axi_awready = !cur.awp;
  assign s_axi_wready = !cur.wp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign lk.ack = cur.ack;
  assign lk.data = cur.ldata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_cur = cur;
    wval = 32'h0;
    // Capture address and data in either order
    if (s_axi_awvalid && !cur.awp)
    begin
      next_cur.awp = 1'b1;
      next_cur.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.wp)
    begin
      next_cur.wp = 1'b1;
      next_cur.wdata = s_axi_wdata;
      next_cur.wstrb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready)
      next_cur.bvalid = 1'b0;
    // Copy setting update sequence, destination word first
    case (cur.st)
      HOST_IDLE:
      begin
      end
      HOST_KILL:
      begin
        next_cur.w0[TYPE_LSB+3:TYPE_LSB] = COPY_INVALID;
        next_cur.st = HOST_DEST;
        next_cur.gap = 8'(STEP_GAP_CYC);
      end
      HOST_DEST:
      begin
        if (cur.gap != 8'h00)
          next_cur.gap = 8'(cur.gap - 8'h01);
        else
        begin
          next_cur.w0 = cur.cmd[15:0];
          next_cur.st = HOST_SRC;
          next_cur.gap = 8'(STEP_GAP_CYC);
        end
      end
      HOST_SRC:
      begin
        if (cur.gap != 8'h00)
          next_cur.gap = 8'(cur.gap - 8'h01);
        else
        begin
          next_cur.w1 = {4'h0, cur.cmd[27:16]};
          next_cur.st = HOST_HOLD;
          next_cur.gap = 8'(STEP_GAP_CYC);
        end
      end
      HOST_HOLD:
      begin
        if (cur.gap != 8'h00)
          next_cur.gap = 8'(cur.gap - 8'h01);
        else
          next_cur.st = HOST_IDLE;
      end
      default:
      begin
        next_cur.st = HOST_IDLE;
      end
    endcase
    // Register write once both halves are held
    if (cur.awp && cur.wp && !cur.bvalid)
    begin
      next_cur.awp = 1'b0;
      next_cur.wp = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      if (cur.awaddr == REG_LOC)
      begin
        wval = merge({12'h0, cur.loc}, cur.wdata, cur.wstrb);
        if (mtc_area_ok(wval[19:16]))
        begin
          next_cur.loc = wval[19:0];
          next_cur.loc_err = 1'b0;
        end
        else
          next_cur.loc_err = 1'b1;
      end
      else if (cur.awaddr == REG_CMD)
      begin
        wval = merge(cur.cmd, cur.wdata, cur.wstrb);
        if (cur.st != HOST_IDLE)
          next_cur.cmd_ref = 1'b1;
        else
        begin
          next_cur.cmd = wval;
          next_cur.cmd_ref = 1'b0;
          next_cur.gap = 8'h00;
          // Same command again needs an invalid type in between
          if (wval[15:0] == cur.w0 && {4'h0, wval[27:16]} == cur.w1)
            next_cur.st = HOST_KILL;
          else
            next_cur.st = HOST_DEST;
        end
      end
      else if (cur.awaddr[7:5] == REG_MEM_HI)
      begin
        wval = merge({16'h0, cur.mem[cur.awaddr[4:2]]}, cur.wdata, cur.wstrb);
        next_cur.mem[cur.awaddr[4:2]] = wval[15:0]; // Only the low half is stored
      end
      else if (cur.awaddr != REG_STATUS && cur.awaddr != REG_WORDS)
        next_cur.bresp = RESP_SLVERR;
    end
    // Register read
    if (cur.rvalid && s_axi_rready)
      next_cur.rvalid = 1'b0;
    else if (s_axi_arvalid && !cur.rvalid)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      if (s_axi_araddr == REG_LOC)
        next_cur.rdata = {12'h0, cur.loc};
      else if (s_axi_araddr == REG_CMD)
        next_cur.rdata = cur.cmd;
      else if (s_axi_araddr == REG_STATUS)
        next_cur.rdata = status;
      else if (s_axi_araddr == REG_WORDS)
        next_cur.rdata = {cur.w1, cur.w0};
      else if (s_axi_araddr[7:5] == REG_MEM_HI)
        next_cur.rdata = {16'h0, cur.mem[s_axi_araddr[4:2]]};
      else
      begin
        next_cur.rdata = 32'h0;
        next_cur.rresp = RESP_SLVERR;
      end
    end
    // Link answer one cycle after a request
    next_cur.ack = lk.req && !cur.ack;
    if (lk.req && !cur.ack)
    begin
      if ({lk.area, lk.addr} == cloc)
        next_cur.ldata = cur.w0;
      else if ({lk.area, lk.addr} == 20'(cloc + 20'h00001))
        next_cur.ldata = cur.w1;
      else if (lk.area == AREA_DATA && lk.addr < 16'(HOST_MEM_N))
        next_cur.ldata = cur.mem[lk.addr[2:0]];
      else
        next_cur.ldata = 16'h0000;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur <= '0;
      cur.loc <= {RST_LOC_AREA, RST_LOC_ADDR};
    end
    else
      cur <= next_cur;
  end
endmodule
`default_nettype wire

// [dv/mtc_link_props.sv]
// Link protocol checker between terminal unit and host controller
`timescale 1ns/1ns
`default_nettype none
module mtc_link_props
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link signals
  input wire logic req,
  input wire logic [3:0] area,
  input wire logic [15:0] addr,
  input wire logic ack,
  input wire logic [15:0] data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Read handshake
  // ----------------------------------------
  AST_ACK_NEXT: assert property (req && !ack |=> ack) else $error("link answer late");
  AST_ACK_SPACED: assert property (ack |=> !ack [*2]) else $error("link answers too close");
  AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("link answer without request");
  AST_REQ_HOLD: assert property (req && !ack |=> req) else $error("request dropped early");
  AST_ADDR_STABLE: assert property (req && !ack |=> $stable(area) && $stable(addr)) else $error("address moved");
  AST_REQ_DROP: assert property (ack |=> !req) else $error("request kept after answer");
  // ----------------------------------------
  // Addressing and polling
  // ----------------------------------------
  AST_RELAY_XLATE: assert property (req |-> !(area == AREA_LINK_RELAY && addr <= LINK_RELAY_LAST)) else $error("relay word not moved");
  AST_POLL_ON: assert property (!req |-> ##[1:4] req) else $error("polling stalled");
  // Main scenarios reached
  cover property (req && area == AREA_GENERAL_IO && addr == 16'h03ed);
  cover property (ack && data != 16'h0000);
  cover property (req && area == AREA_DATA);
endmodule
`default_nettype wire

// [dv/memory_table_copy_command_tb.sv]
// Bench joining terminal unit and host controller over the word link
`timescale 1ns/1ns
`default_nettype none
module memory_table_copy_command_tb
  import mtc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] ctrl_area = 4'ha;
  logic [15:0] ctrl_addr = 16'h0004;
  logic alloc_en = 1'b1;
  logic disp_num = 1'b0;
  logic [6:0] disp_idx = 7'h02;
  logic look_num = 1'b0;
  logic [6:0] look_idx = 7'h00;
  logic [15:0] disp_data, look_data;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, copy_done, init_done;
  logic [1:0] bresp, rresp;
  int n_fail = 0, samples_checked = 0, n_copy = 0, cyc = 0;
  // ----------------------------------------
  // Clock, design and checker
  // ----------------------------------------
  always #20 clk = ~clk;
  mtc_link_if lk (.clk(clk));
  mtc_dev i_mtc_dev (.clk(clk), .arst_n(arst_n), .lk(lk.dev), .ctrl_area(ctrl_area), .ctrl_addr(ctrl_addr),
    .alloc_en(alloc_en), .alloc_area(AREA_DATA), .alloc_base(16'h0000), .disp_num(disp_num), .disp_idx(disp_idx),
    .disp_data(disp_data), .look_num(look_num), .look_idx(look_idx), .look_data(look_data),
    .copy_done(copy_done), .init_done(init_done));
  mtc_host i_mtc_host (.clk(clk), .arst_n(arst_n), .lk(lk.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mtc_link_props i_mtc_link_props (.clk(clk), .arst_n(arst_n), .req(lk.req), .area(lk.area), .addr(lk.addr),
    .ack(lk.ack), .data(lk.data));
  // Copy counter and hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (copy_done === 1'b1)
      n_copy <= n_copy + 1;
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // AXI write, ready sampled on the falling edge before the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
    end
  endtask
  // AXI read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
    end
  endtask
  // Wait until the host has written both words and the terminal has seen them
  task automatic settle();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h1;
    while (d[0] !== 1'b0)
      axr(REG_STATUS, d, r);
    wait_cyc(20);
  endtask
  // Order a copy and wait until it is carried out
  task automatic cmd(input logic [3:0] t, input logic [11:0] dst, input logic [11:0] src);
    logic [1:0] r;
    axw(REG_CMD, {4'h0, src, t, dst}, r);
    settle();
  endtask
  task automatic look(input logic n, input logic [6:0] i, input logic [15:0] exp);
    @(posedge clk);
    look_num <= n;
    look_idx <= i;
    @(posedge clk);
    @(negedge clk);
    chk("look_data", {16'h0, exp}, {16'h0, look_data});
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int c;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Valid copy words already present at the first sample must not copy
    axw(8'h30, 32'h0003, r);
    axw(8'h34, 32'h0002, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    while (init_done !== 1'b1)
      @(posedge clk);
    wait_cyc(40);
    chk("copy count", 32'h0, n_copy);
    ctrl_addr <= 16'h0000;
    axw(8'h28, 32'h1234, r);
    wait_cyc(40);
    chk("disp_data", 32'h1234, {16'h0, disp_data});
    cmd(COPY_NUMERAL, 12'h100, 12'h002);
    look(1'b0, 7'h64, 16'h0000);
    cmd(COPY_STRING, 12'h100, 12'h002);
    look(1'b0, 7'h64, 16'h1234);
    axw(8'h28, 32'h5678, r);
    wait_cyc(40);
    cmd(COPY_STRING, 12'h100, 12'h002);
    look(1'b0, 7'h64, 16'h5678);
    c = n_copy;
    wait_cyc(200);
    chk("copy count", c, n_copy);
    cmd(4'h2, 12'h101, 12'h002);
    cmd(4'h2, 12'h101, 12'h128);
    chk("copy count", c, n_copy);
    cmd(COPY_STRING, 12'h101, 12'h128);
    chk("copy count", c, n_copy);
    look(1'b0, 7'h65, 16'h0000);
    // Destination word lands first; a second order while busy is refused
    axw(REG_CMD, {4'h0, 12'h002, COPY_STRING, 12'h127}, r);
    axr(REG_WORDS, d, r);
    chk("words", {16'h0128, 16'h0127}, d);
    axw(REG_CMD, {4'h0, 12'h002, COPY_STRING, 12'h101}, r);
    axr(REG_STATUS, d, r);
    chk("busy cmd_ref", 32'h3, {30'h0, d[1:0]});
    settle();
    look(1'b0, 7'h7f, 16'h5678);
    chk("copy count", c + 1, n_copy);
    @(posedge clk);
    disp_idx <= 7'h7f;
    wait_cyc(40);
    chk("disp_data", 32'h0, {16'h0, disp_data});
    // Without allocation the displayed entry is no longer refreshed
    alloc_en <= 1'b0;
    disp_idx <= 7'h02;
    axw(8'h28, 32'h9abc, r);
    wait_cyc(40);
    chk("disp_data", 32'h5678, {16'h0, disp_data});
    axw(REG_LOC, {12'h0, 4'h4, 16'h0000}, r);
    axr(REG_STATUS, d, r);
    chk("loc_err", 32'h1, {31'h0, d[2]});
    axr(8'h10, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axw(REG_LOC, {12'h0, 4'h3, 16'h0005}, r);
    ctrl_area <= 4'h3;
    ctrl_addr <= 16'h0005;
    axr(REG_LOC, d, r);
    chk("loc", 32'h00030005, d);
    wait_cyc(60);
    close_out();
  end
endmodule
`default_nettype wire
